// ---- common/spl_pkg.sv ----
// constants, types and address helpers for the self-programming lock block
package spl_pkg;

    // ********************************************************
    // flash geometry
    // ********************************************************
    localparam int          WORD_AW    = 14;
    localparam int          PAGE_WB    = 6;
    localparam int          PAGE_AW    = WORD_AW - PAGE_WB;
    localparam logic [13:0] HALT_START = 14'h3800;
    localparam logic [13:0] LDR_START0 = 14'h3800;
    localparam logic [13:0] LDR_START1 = 14'h3c00;
    localparam logic [13:0] LDR_START2 = 14'h3e00;
    localparam logic [13:0] LDR_START3 = 14'h3f00;
    localparam logic [13:0] APP_RESET  = 14'h0000;

    // ********************************************************
    // control register codes, low five bits
    // ********************************************************
    localparam logic [4:0] CTRL_FILL   = 5'h01;
    localparam logic [4:0] CTRL_ERASE  = 5'h03;
    localparam logic [4:0] CTRL_LOCK   = 5'h09;
    localparam logic [4:0] CTRL_REREAD = 5'h11;

    // ********************************************************
    // lock bits: [5:4] loader, [3:2] application, [1:0] general
    // ********************************************************
    localparam logic [5:0] LOCK_UNPROG = 6'h3f;
    localparam logic [5:0] LOCK_RESET  = 6'h00;
    localparam int         LOCK_LDR    = 4;
    localparam int         LOCK_APP    = 2;

    // ********************************************************
    // timing and erased buffer value
    // ********************************************************
    localparam logic [2:0]  WIN_CYCLES       = 3'h4;
    localparam logic [15:0] ERASE_CYCLES_DEF = 16'h0064;
    localparam logic [15:0] BUF_ERASED       = 16'hffff;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_FILL,
        CMD_ERASE,
        CMD_LOCK,
        CMD_REREAD
    } spl_cmd_t;

    function automatic logic [13:0] loader_start(input logic [1:0] cfg);
        case (cfg)
            2'h3:    loader_start = LDR_START3;
            2'h2:    loader_start = LDR_START2;
            2'h1:    loader_start = LDR_START1;
            default: loader_start = LDR_START0;
        endcase
    endfunction

    function automatic logic in_loader(input logic [13:0] a,
                                       input logic [1:0]  cfg);
        in_loader = (a >= loader_start(cfg));
    endfunction

    function automatic logic in_halting(input logic [13:0] a);
        in_halting = (a >= HALT_START);
    endfunction

    function automatic logic [13:0] ptr_word(input logic [15:0] z);
        ptr_word = z[WORD_AW:1];
    endfunction

    function automatic logic [PAGE_AW-1:0] ptr_page(input logic [15:0] z);
        ptr_page = z[WORD_AW:PAGE_WB+1];
    endfunction

    function automatic logic [PAGE_WB-1:0] ptr_wsel(input logic [15:0] z);
        ptr_wsel = z[PAGE_WB:1];
    endfunction

endpackage

// ---- common/spl_pbuf_if.sv ----
// carrier between the sequencer and the temporary page buffer
`timescale 1ns/100ps
interface spl_pbuf_if #(parameter int DEPTH_W = 6);
    logic               wr;
    logic               clr;
    logic [DEPTH_W-1:0] widx;
    logic [15:0]        wdata;
    logic [DEPTH_W-1:0] ridx;
    logic [15:0]        rdata;
    modport ctl (output wr, clr, widx, wdata, ridx, input rdata);
    modport mem (input wr, clr, widx, wdata, ridx, output rdata);
endinterface

// ---- core/spl_pbuf.sv ----
// temporary page buffer with registered read data
`timescale 1ns/100ps
module spl_pbuf #(
    parameter int DEPTH_W = 6
) (
    input  wire logic SYS_CLK,
    input  wire logic RESET_N,
    spl_pbuf_if.mem   pb
);
    typedef struct packed {
        logic [(1<<DEPTH_W)-1:0][15:0] mem;
        logic [15:0]                   rdata;
    } spl_pbuf_st_t;

    spl_pbuf_st_t s_r;
    spl_pbuf_st_t s_nxt;

    // ********************************************************
    // storage
    // ********************************************************
    // erased content reads as all ones, like blank flash
    always_comb begin
        s_nxt = s_r;
        if (pb.clr) begin
            s_nxt.mem = '1;
        end else if (pb.wr) begin
            s_nxt.mem[pb.widx] = pb.wdata;
        end
        s_nxt.rdata = s_r.mem[pb.ridx];
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pb.rdata = s_r.rdata;
endmodule

// ---- core/spl_lockchk.sv ----
// section lock decode: store, load and interrupt gating
`timescale 1ns/100ps
module spl_lockchk (
    input  wire logic [1:0] app_lock,
    input  wire logic [1:0] ldr_lock,
    input  wire logic       exec_ldr,
    input  wire logic       tgt_ldr,
    input  wire logic       ivec_ldr,
    output logic            store_block,
    output logic            load_block,
    output logic            irq_mask
);
    // bit0 zero means mode 2 or 3, bit1 zero means mode 3 or 4;
    // both ones is mode 1 and leaves the section open [R4]
    assign store_block = tgt_ldr ? !ldr_lock[0] : !app_lock[0]; // [R5] [R8]
    assign load_block  = (!tgt_ldr && exec_ldr && !app_lock[1]) // [R6]
                      || (tgt_ldr && !exec_ldr && !ldr_lock[1]); // [R9]
    assign irq_mask    = (!app_lock[1] && ivec_ldr && !exec_ldr) // [R7]
                      || (!ldr_lock[1] && !ivec_ldr && exec_ldr); // [R10]
endmodule

// ---- core/spl_selfprog.sv ----
// self-programming sequencer: section locks, page buffer fill, page erase
`timescale 1ns/100ps

// Behaviour
// R1: lock bits only get programmed; chip erase alone returns them to ones.
// R2: general lock bits never block store or load accesses.
// R3: stored one means unprogrammed, zero means programmed.
// R4: lock field 11 leaves the section unrestricted.
// R5: application field 10 or 00 refuses stores to the application section.
// R6: application field 00 or 01 refuses loader-run loads of application.
// R7: those application modes mask interrupts in application when vectors sit in loader.
// R8: loader field 10 or 00 refuses stores to the loader section.
// R9: loader field 00 or 01 refuses application-run loads of loader.
// R10: those loader modes mask interrupts in loader when vectors sit in application.
// R11: reset vector is zero with fuse one, loader start with fuse zero.
// R12: no instruction path can alter fuses.
// R13: pointer is high byte over low byte, sixteen bits.
// R14: pointer low bits pick word in page, high bits pick page.
// R15: erase page is latched at start; pointer changes do not matter.
// R16: lock-setting store ignores the pointer completely.
// R17: loads are bytewise; pointer bit 0 picks low or high byte.
// R18: buffer fills one word per store, before or after an erase.
// R19: buffer words may be written at any position in any order.
// R20: software erases a page first and uses one page address throughout.
// R21: erase code then a store within four cycles erases; data ignored.
// R22: concurrent-region erase keeps fetching; halting-region erase stalls the CPU.
// R23: busy flag reads one while concurrent region is blocked.
// R24: enable bit opens a four-cycle store window, then clears itself.
// R25: refused store changes nothing and has no side effect.
// R26: section membership uses boot size boundary for executing and target addresses.
module spl_selfprog #(
    parameter logic [15:0] ERASE_CYCLES = spl_pkg::ERASE_CYCLES_DEF
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        CTRL_WR,
    input  wire logic [7:0]  CTRL_DATA,
    input  wire logic        STORE_REQ,
    input  wire logic        LOAD_REQ,
    input  wire logic [7:0]  PTR_HIGH,
    input  wire logic [7:0]  PTR_LOW,
    input  wire logic [7:0]  DATA_HIGH,
    input  wire logic [7:0]  DATA_LOW,
    input  wire logic [13:0] EXEC_ADDR,
    input  wire logic        IVEC_IN_LOADER,
    input  wire logic [1:0]  BOOT_SIZE_CFG,
    input  wire logic        BOOT_VECTOR_FUSE,
    input  wire logic [5:0]  LOCK_NV_IN,
    input  wire logic        EXT_LOCK_WR,
    input  wire logic [5:0]  EXT_LOCK_DATA,
    input  wire logic        CHIP_ERASE,
    input  wire logic [5:0]  BUF_RD_IDX,
    output logic [13:0]      RESET_VECTOR,
    output logic             SELFPROG_EN,
    output logic             REGION_BUSY,
    output logic             CPU_HALT,
    output logic             ERASE_ACTIVE,
    output logic [7:0]       ERASE_PAGE,
    output logic             STORE_DONE,
    output logic             STORE_REFUSED,
    output logic             LOAD_GRANT,
    output logic             LOAD_REFUSED,
    output logic             LOAD_BYTE_HI,
    output logic [13:0]      LOAD_WORD_ADDR,
    output logic             IRQ_MASK,
    output logic [5:0]       LOCK_BITS,
    output logic [15:0]      BUF_RD_DATA
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic                          init;
        spl_pkg::spl_cmd_t             cmd;
        logic [2:0]                    win;
        logic                          en;
        logic                          ers;
        logic [spl_pkg::PAGE_AW-1:0]   page;
        logic [15:0]                   ecnt;
        logic                          halt;
        logic                          busy;
        logic [5:0]                    lock;
        logic                          st_done;
        logic                          st_ref;
        logic                          ld_ok;
        logic                          ld_ref;
        logic                          ld_hi;
        logic [13:0]                   ld_addr;
        logic                          irq_m;
        logic [13:0]                   rvec;
        logic [15:0]                   bufq;
    } spl_state_t;

    spl_state_t st_r;
    spl_state_t st_nxt;

    logic [15:0] zptr;
    logic [13:0] tgt_word;
    logic        tgt_ldr;
    logic        exec_ldr;
    logic        store_block;
    logic        load_block;
    logic        irq_mask;
    logic        store_ok;
    logic        fill_go;
    logic        reread_go;
    logic        tgt_halt;

    spl_pbuf_if #(.DEPTH_W(spl_pkg::PAGE_WB)) pb ();

    // ********************************************************
    // address decode
    // ********************************************************
    assign zptr     = {PTR_HIGH, PTR_LOW}; // [R13]
    assign tgt_word = spl_pkg::ptr_word(zptr); // [R14]
    assign tgt_ldr  = spl_pkg::in_loader(tgt_word, BOOT_SIZE_CFG); // [R26]
    assign exec_ldr = spl_pkg::in_loader(EXEC_ADDR, BOOT_SIZE_CFG); // [R26]
    assign tgt_halt = spl_pkg::in_halting(tgt_word);

    // general lock bits [1:0] are held but never enter this check
    spl_lockchk u_lockchk (
        .app_lock    (st_r.lock[spl_pkg::LOCK_APP +: 2]), // [R2]
        .ldr_lock    (st_r.lock[spl_pkg::LOCK_LDR +: 2]),
        .exec_ldr    (exec_ldr),
        .tgt_ldr     (tgt_ldr),
        .ivec_ldr    (IVEC_IN_LOADER),
        .store_block (store_block),
        .load_block  (load_block),
        .irq_mask    (irq_mask)
    );

    // ********************************************************
    // store acceptance
    // ********************************************************
    // stores only run from the loader, inside the window, not while erasing
    assign store_ok = STORE_REQ && (st_r.win != 3'h0) && !st_r.ers
                   && exec_ldr
                   && !(st_r.cmd == spl_pkg::CMD_ERASE && store_block); // [R25]
    assign fill_go   = store_ok && (st_r.cmd == spl_pkg::CMD_FILL); // [R18]
    assign reread_go = store_ok && (st_r.cmd == spl_pkg::CMD_REREAD);

    assign pb.wr    = fill_go;
    assign pb.clr   = reread_go;
    assign pb.widx  = spl_pkg::ptr_wsel(zptr); // [R19]
    assign pb.wdata = {DATA_HIGH, DATA_LOW};
    assign pb.ridx  = BUF_RD_IDX;

    spl_pbuf #(.DEPTH_W(spl_pkg::PAGE_WB)) u_pbuf (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .pb      (pb)
    );

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        st_nxt         = st_r;
        st_nxt.st_done = 1'b0;
        st_nxt.st_ref  = 1'b0;
        st_nxt.ld_ok   = 1'b0;
        st_nxt.ld_ref  = 1'b0;

        // window runs down every cycle; empty window drops the command unless an erase runs
        if (st_r.win != 3'h0) begin
            st_nxt.win = st_r.win - 3'h1; // [R24]
        end
        if (st_nxt.win == 3'h0 && !st_r.ers) begin
            st_nxt.cmd = spl_pkg::CMD_NONE; // [R24]
        end

        // erase runs to its end; busy flag outlives it until reread
        if (st_r.ers) begin
            if (st_r.ecnt == 16'h0000) begin
                st_nxt.ers  = 1'b0;
                st_nxt.halt = 1'b0;
                st_nxt.cmd  = spl_pkg::CMD_NONE;
            end else begin
                st_nxt.ecnt = st_r.ecnt - 16'h0001;
            end
        end

        if (STORE_REQ) begin
            st_nxt.st_ref  = !store_ok; // [R25]
            st_nxt.st_done = store_ok;
        end

        if (store_ok) begin
            st_nxt.win = 3'h0;
            st_nxt.cmd = spl_pkg::CMD_NONE;
            case (st_r.cmd)
                spl_pkg::CMD_ERASE: begin
                    // only page bits are taken; data and word bits ignored
                    st_nxt.cmd  = spl_pkg::CMD_ERASE; // [R21]
                    st_nxt.ers  = 1'b1;
                    st_nxt.page = spl_pkg::ptr_page(zptr); // [R15]
                    st_nxt.ecnt = ERASE_CYCLES - 16'h0001;
                    if (tgt_halt) begin
                        st_nxt.halt = 1'b1; // [R22]
                    end else begin
                        st_nxt.busy = 1'b1; // [R22] [R23]
                    end
                end
                spl_pkg::CMD_LOCK: begin
                    // pointer plays no part here
                    st_nxt.lock = st_r.lock & DATA_LOW[5:0]; // [R16] [R1]
                end
                spl_pkg::CMD_REREAD: begin
                    st_nxt.busy = 1'b0; // [R23]
                end
                default: begin
                end
            endcase
        end

        // a valid code arms a fresh window unless an erase runs; anything else is ignored
        if (CTRL_WR && !st_r.ers) begin
            case (CTRL_DATA[4:0])
                spl_pkg::CTRL_FILL: begin
                    st_nxt.cmd = spl_pkg::CMD_FILL;
                    st_nxt.win = spl_pkg::WIN_CYCLES; // [R24]
                end
                spl_pkg::CTRL_ERASE: begin
                    st_nxt.cmd = spl_pkg::CMD_ERASE; // [R21]
                    st_nxt.win = spl_pkg::WIN_CYCLES;
                end
                spl_pkg::CTRL_LOCK: begin
                    st_nxt.cmd = spl_pkg::CMD_LOCK;
                    st_nxt.win = spl_pkg::WIN_CYCLES;
                end
                spl_pkg::CTRL_REREAD: begin
                    st_nxt.cmd = spl_pkg::CMD_REREAD;
                    st_nxt.win = spl_pkg::WIN_CYCLES;
                end
                default: begin
                end
            endcase
        end
        st_nxt.en = (st_nxt.win != 3'h0) || st_nxt.ers; // [R24]

        // nonvolatile locks arrive once after reset; ones never come back
        // except through chip erase
        if (!st_r.init) begin
            st_nxt.init = 1'b1;
            st_nxt.lock = LOCK_NV_IN; // [R3]
        end else if (CHIP_ERASE) begin
            st_nxt.lock = spl_pkg::LOCK_UNPROG; // [R1] [R3]
        end else if (EXT_LOCK_WR) begin
            st_nxt.lock = st_nxt.lock & EXT_LOCK_DATA; // [R1]
        end

        if (LOAD_REQ) begin
            st_nxt.ld_addr = tgt_word;
            st_nxt.ld_hi   = PTR_LOW[0]; // [R17]
            st_nxt.ld_ok   = !load_block; // [R6] [R9]
            st_nxt.ld_ref  = load_block;
        end

        st_nxt.irq_m = irq_mask; // [R7] [R10]
        // fuses are inputs only; nothing here writes them
        st_nxt.rvec  = BOOT_VECTOR_FUSE ? spl_pkg::APP_RESET // [R11] [R12]
                     : spl_pkg::loader_start(BOOT_SIZE_CFG);
        st_nxt.bufq  = pb.rdata;
    end

    // most restrictive locks until the stored ones are read in
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r      <= '0;
            st_r.cmd  <= spl_pkg::CMD_NONE;
            st_r.lock <= spl_pkg::LOCK_RESET;
            st_r.bufq <= spl_pkg::BUF_ERASED;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign RESET_VECTOR   = st_r.rvec;
    assign SELFPROG_EN    = st_r.en;
    assign REGION_BUSY    = st_r.busy;
    assign CPU_HALT       = st_r.halt;
    assign ERASE_ACTIVE   = st_r.ers;
    assign ERASE_PAGE     = st_r.page;
    assign STORE_DONE     = st_r.st_done;
    assign STORE_REFUSED  = st_r.st_ref;
    assign LOAD_GRANT     = st_r.ld_ok;
    assign LOAD_REFUSED   = st_r.ld_ref;
    assign LOAD_BYTE_HI   = st_r.ld_hi;
    assign LOAD_WORD_ADDR = st_r.ld_addr;
    assign IRQ_MASK       = st_r.irq_m;
    assign LOCK_BITS      = st_r.lock;
    assign BUF_RD_DATA    = st_r.bufq;

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_arm;
        CTRL_WR && !ERASE_ACTIVE && (CTRL_DATA[4:0] == spl_pkg::CTRL_FILL);
    endsequence

    sequence s_erase_go;
        store_ok && (st_r.cmd == spl_pkg::CMD_ERASE);
    endsequence

    property p_win_close;
        s_arm ##1 (!STORE_REQ && !CTRL_WR)[*4] |=> !SELFPROG_EN;
    endproperty
    a_win_close: assert property (p_win_close) // [R24]
        else $error("enable bit outlived its four-cycle window");

    property p_app_store;
        STORE_REQ && st_r.cmd == spl_pkg::CMD_ERASE && !tgt_ldr
            && !st_r.lock[spl_pkg::LOCK_APP]
            |=> STORE_REFUSED && !$rose(ERASE_ACTIVE);
    endproperty
    a_app_store: assert property (p_app_store) // [R5]
        else $error("locked application erase was not refused");

    property p_ldr_store;
        STORE_REQ && st_r.cmd == spl_pkg::CMD_ERASE && tgt_ldr
            && !st_r.lock[spl_pkg::LOCK_LDR]
            |=> STORE_REFUSED && !$rose(ERASE_ACTIVE);
    endproperty
    a_ldr_store: assert property (p_ldr_store) // [R8]
        else $error("locked loader erase was not refused");

    property p_app_load;
        LOAD_REQ && exec_ldr && !tgt_ldr && !st_r.lock[spl_pkg::LOCK_APP+1]
            |=> LOAD_REFUSED && !LOAD_GRANT;
    endproperty
    a_app_load: assert property (p_app_load) // [R6]
        else $error("locked application load was granted");

    property p_ldr_load;
        LOAD_REQ && !exec_ldr && tgt_ldr && !st_r.lock[spl_pkg::LOCK_LDR+1]
            |=> LOAD_REFUSED && !LOAD_GRANT;
    endproperty
    a_ldr_load: assert property (p_ldr_load) // [R9]
        else $error("locked loader load was granted");

    property p_lock_sticky;
        st_r.init && !CHIP_ERASE |=> (LOCK_BITS & ~$past(LOCK_BITS)) == 6'h00;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) // [R1]
        else $error("lock bit returned to one without chip erase");

    property p_erase_region;
        s_erase_go |=> ERASE_ACTIVE
            && (CPU_HALT == $past(tgt_halt))
            && (CPU_HALT || REGION_BUSY);
    endproperty
    a_erase_region: assert property (p_erase_region) // [R22]
        else $error("erase halt or busy does not match region");

    property p_page_hold;
        ERASE_ACTIVE ##1 ERASE_ACTIVE |-> $stable(ERASE_PAGE);
    endproperty
    a_page_hold: assert property (p_page_hold) // [R15]
        else $error("erase page moved during erase");

    property p_busy_hold;
        ERASE_ACTIVE && REGION_BUSY |=> REGION_BUSY;
    endproperty
    a_busy_hold: assert property (p_busy_hold) // [R23]
        else $error("busy flag dropped while region blocked");

    property p_irq_app;
        IVEC_IN_LOADER && !exec_ldr && !st_r.lock[spl_pkg::LOCK_APP+1]
            |=> IRQ_MASK;
    endproperty
    a_irq_app: assert property (p_irq_app) // [R7]
        else $error("interrupts not masked in locked application");

    property p_rvec;
        ##1 1'b1 |-> RESET_VECTOR == ($past(BOOT_VECTOR_FUSE) ? 14'h0000
            : spl_pkg::loader_start($past(BOOT_SIZE_CFG)));
    endproperty
    a_rvec: assert property (p_rvec) // [R11]
        else $error("reset vector disagrees with boot vector fuse");

endmodule

// ---- bench/spl_cpu_model.sv ----
// cpu-side partner: control writes, program stores and program loads
`timescale 1ns/100ps
module spl_cpu_model (
    input  wire logic        clk,
    input  wire logic        done,
    input  wire logic        grant,
    output logic             ctrl_wr,
    output logic [7:0]       ctrl_data,
    output logic             store_req,
    output logic             load_req,
    output logic [15:0]      ptr,
    output logic [15:0]      dat,
    output logic [13:0]      exec
);
    // ********************************************************
    // instruction tasks, all changes 1 ns after the edge
    // ********************************************************
    initial begin
        ctrl_wr = 1'b0;
        ctrl_data = 8'h00;
        store_req = 1'b0;
        load_req = 1'b0;
        ptr = 16'h0000;
        dat = 16'h0000;
        exec = 14'h0000;
    end
    // gap above 3 deliberately misses the store window
    task program_store_instr(input logic [7:0] c, input int gap, input logic [15:0] z,
             input logic [15:0] d, input logic [13:0] ex, output logic ok);
        @(posedge clk) #1;
        ctrl_wr = 1'b1;
        ctrl_data = c;
        ptr = z;
        dat = d;
        exec = ex;
        @(posedge clk) #1;
        ctrl_wr = 1'b0;
        repeat (gap) @(posedge clk) #1;
        store_req = 1'b1;
        @(posedge clk) #1;
        store_req = 1'b0;
        ptr = ~z; // pointer reused at once, must not matter
        dat = ~d;
        ok = done;
    endtask
    task lpm(input logic [15:0] z, input logic [13:0] ex, output logic ok);
        @(posedge clk) #1;
        load_req = 1'b1;
        ptr = z;
        exec = ex;
        @(posedge clk) #1;
        load_req = 1'b0;
        ok = grant;
    endtask
    task idle(input logic [13:0] ex);
        @(posedge clk) #1;
        exec = ex;
        @(posedge clk) #1;
    endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the self-programming lock block
`timescale 1ns/100ps
module tb_top;
    // ********************************************************
    // stimulus, expectations and verdict
    // ********************************************************
    logic clk = 1'b0, rst_n = 1'b0, ld_req, ivec = 1'b0, fuse = 1'b1;
    logic ce = 1'b0, done, grant, ok, wr, st, erase, halt, busy, byte_hi;
    logic [1:0] cfg = 2'h0, ap, ld;
    logic [5:0] nv = 6'h3f, ridx = 6'h00, lockb;
    logic [7:0] cd, epage;
    logic [13:0] ex, rvec, la;
    logic xw = 1'b0, irq;
    logic [15:0] z, d, p, dt, rdat;
    int err_total = 0, n_checks = 0, seed = 67, i;
    initial forever #12.5 clk = ~clk;
    spl_selfprog #(.ERASE_CYCLES(16'h0004)) spl_selfprog_inst (
        .SYS_CLK(clk), .RESET_N(rst_n), .CTRL_WR(wr), .CTRL_DATA(cd),
        .STORE_REQ(st), .LOAD_REQ(ld_req), .PTR_HIGH(p[15:8]),
        .PTR_LOW(p[7:0]), .DATA_HIGH(dt[15:8]), .DATA_LOW(dt[7:0]),
        .EXEC_ADDR(ex), .IVEC_IN_LOADER(ivec), .BOOT_SIZE_CFG(cfg),
        .BOOT_VECTOR_FUSE(fuse), .LOCK_NV_IN(nv), .EXT_LOCK_WR(xw),
        .EXT_LOCK_DATA(6'h3b), .CHIP_ERASE(ce), .BUF_RD_IDX(ridx),
        .RESET_VECTOR(rvec), .SELFPROG_EN(), .REGION_BUSY(busy),
        .CPU_HALT(halt), .ERASE_ACTIVE(erase), .ERASE_PAGE(epage),
        .STORE_DONE(done), .STORE_REFUSED(), .LOAD_GRANT(grant),
        .LOAD_REFUSED(), .LOAD_BYTE_HI(byte_hi), .LOAD_WORD_ADDR(la),
        .IRQ_MASK(irq), .LOCK_BITS(lockb), .BUF_RD_DATA(rdat));
    spl_cpu_model spl_cpu_model_inst (.clk(clk), .done(done), .grant(grant),
        .ctrl_wr(wr), .ctrl_data(cd), .store_req(st), .load_req(ld_req),
        .ptr(p), .dat(dt), .exec(ex));
    function automatic logic [13:0] exp_vec(logic f, logic [1:0] c);
        exp_vec = f ? spl_pkg::APP_RESET : (c == 2'h3) ? spl_pkg::LDR_START3 :
                  (c == 2'h2) ? spl_pkg::LDR_START2 :
                  (c == 2'h1) ? spl_pkg::LDR_START1 : spl_pkg::LDR_START0;
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                $time, m, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task do_reset(input logic [5:0] locks);
        rst_n = 1'b0;
        nv = locks;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk) #1;
    endtask
    // bounded wait, erase is only four cycles here
    task wait_idle;
        for (i = 0; i < 40 && erase !== 1'b0; i++) @(posedge clk) #1;
        chk(erase, 1'b0, "erase never ended");
    endtask
    initial begin
        #(25 * 20000);
        err_total++;
        tally_and_finish;
    end
    initial begin
        for (int m = 0; m < 16; m++) begin
            {ld, ap} = m[3:0];
            cfg = $random(seed);
            fuse = $random(seed);
            do_reset({ld, ap, 2'b00}); // general lock fully set
            chk(lockb, {ld, ap, 2'b00}, "lock bits");
            chk(rvec, exp_vec(fuse, cfg), "reset vector");
            z = $random(seed) & 16'h3fff;
            spl_cpu_model_inst.program_store_instr(8'h83, $random(seed) & 3, z, 16'h1234,
                                   spl_pkg::LDR_START3, ok);
            chk(ok, ap[0], "app erase");
            if (ok) chk(busy, 1'b1, "region busy");
            if (ok) chk(epage, z[14:7], "erase page");
            wait_idle;
            z = 16'h7e00 | ($random(seed) & 16'h01ff);
            spl_cpu_model_inst.program_store_instr(8'h03, 3, z, 16'h0000,
                                   spl_pkg::LDR_START3, ok);
            chk(ok, ld[0], "loader erase");
            if (ok) chk(halt, 1'b1, "cpu halt");
            wait_idle;
            spl_cpu_model_inst.lpm(z & 16'h3fff, spl_pkg::LDR_START3, ok);
            chk(ok, ap[1], "app load");
            spl_cpu_model_inst.lpm(z, 14'h0100, ok);
            chk(ok, ld[1], "loader load");
            chk(byte_hi, z[0], "byte select");
            chk(la, z[14:1], "load word");
            ivec = 1'b1;
            spl_cpu_model_inst.idle(14'h0100);
            chk(irq, !ap[1], "app irq mask");
            ivec = 1'b0;
            spl_cpu_model_inst.idle(spl_pkg::LDR_START3);
            chk(irq, !ld[1], "loader irq mask");
            spl_cpu_model_inst.program_store_instr(8'h11, 0, z, z, spl_pkg::LDR_START3, ok);
            chk(busy, 1'b0, "busy cleared");
        end
        do_reset(6'h3f);
        for (int k = 0; k < 6; k++) begin
            z = $random(seed);
            d = $random(seed);
            spl_cpu_model_inst.program_store_instr(8'h01, k&3, z, d, spl_pkg::LDR_START3, ok);
            chk(ok, 1'b1, "fill");
            ridx = z[6:1];
            repeat (2) @(posedge clk) #1;
            chk(rdat, d, "buffer word");
        end
        spl_cpu_model_inst.program_store_instr(8'h01, 0, z, d, 14'h0100, ok);
        chk(ok, 1'b0, "store from app");
        spl_cpu_model_inst.program_store_instr(8'h01, 4, z, ~d, spl_pkg::LDR_START3, ok);
        chk(ok, 1'b0, "window expired");
        chk(rdat, d, "buffer unchanged");
        spl_cpu_model_inst.program_store_instr(8'h09, 0, $random(seed), 16'h00c5,
                               spl_pkg::LDR_START3, ok);
        spl_cpu_model_inst.program_store_instr(8'h09, 1, $random(seed), 16'h00ff,
                               spl_pkg::LDR_START3, ok);
        @(posedge clk) #1;
        chk(lockb, 6'h05, "lock set only programs");
        xw = 1'b1;
        @(posedge clk) #1;
        chk(lockb, 6'h01, "external lock");
        ce = 1'b1;
        @(posedge clk) #1;
        {ce, xw} = 2'b00;
        @(posedge clk) #1;
        chk(lockb, 6'h3f, "chip erase");
        tally_and_finish;
    end
endmodule
